//--- hw/vic_control_status.sv
/*
  vectored interrupt control and status: mode select, proximity timer,
  external edge polarity, presented level/slot report, pending flags,
  enables and priorities, with clear/set/invert aliases.
  assumes a strobe register port and a cpu that takes o_cpu_req when valid.
*/
// Implementation choices: strobed register access and the address map.
// Functional notes
// - control bit 12 selects multi-slot mode when one, single-slot when zero.
// - trigger level one to seven starts timer for priorities at or below it.
// - trigger level zero keeps the proximity timer disabled.
// - external inputs detect rising edge when polarity bit one, falling when zero.
// - status bits 10 to 8 show priority of latest presented request.
// - status bits 5 to 0 show the slot number currently presented.
// - reload value loads into the proximity timer on each trigger.
// - a source request sets its pending flag; zero means none occurred.
// - unimplemented bits read zero and ignore writes.
// - a request is forwarded only when its enable bit is one.
// - priority zero disables a source; subpriority ranges zero to three.
// - clear, set and invert aliases at plus 4, 8 and C act on ones.
module vic_control_status
  import vic_pkg::*;
(
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rst,
  input  wire logic [7:0]             i_addr,
  input  wire logic [31:0]            i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [31:0]            o_rdata,
  input  wire logic [VIC_NUM_SRC-1:0] i_src_req,
  input  wire logic [VIC_NUM_EXT-1:0] i_ext_pin,
  output vic_pkg::vic_cpu_req_t       o_cpu_req,
  output logic                        o_multi_slot,
  output logic                        o_irq
);
  import vic_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0]          control_r;
    logic [31:0]          status_r;
    logic [31:0]          reload_r;
    logic [31:0]          pending_r;
    logic [31:0]          enable_r;
    logic [31:0]          prio_lo_r;
    logic [31:0]          prio_hi_r;
    logic [31:0]          timer_r;
    vic_tmr_state_t       tmr_r;
    logic [VIC_NUM_EVT-1:0] evt_r;
    logic [VIC_NUM_EVT-1:0] evt_en_r;
    vic_cpu_req_t         cpu_r;
    logic [31:0]          rdata_r;
  } vic_state_t;

  vic_state_t st_r;
  vic_state_t st_nxt;

  // priority field of source n: one 5-bit field per byte, shared by four sources, 16 sources per word
  function automatic logic [4:0] prio_of(input logic [31:0] lo, input logic [31:0] hi,
                                         input int n);
    logic [63:0] both;
    both = {hi, lo};
    return both[(n/4)*8 +: 5];
  endfunction

  // alias write: plain, clear, set, invert on bits written as one
  function automatic logic [31:0] alias_wr(input logic [31:0] cur, input logic [31:0] wd,
                                           input logic [1:0] kind, input logic [31:0] mask);
    logic [31:0] res;
    res = cur;
    case (kind)
      VIC_ALIAS_PLAIN: res = wd;
      VIC_ALIAS_CLR:   res = cur & ~wd;
      VIC_ALIAS_SET:   res = cur | wd;
      VIC_ALIAS_INV:   res = cur ^ wd;
      default:         res = cur;
    endcase
    return res & mask;
  endfunction

  // ----------------------------------------------------------------
  // external edges
  // ----------------------------------------------------------------
  logic [VIC_NUM_EXT-1:0] ext_edge;

  vic_edge_detect u_edge
  (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_pin     (i_ext_pin),
    .i_rising  (st_r.control_r[VIC_NUM_EXT-1:0]),
    .o_edge    (ext_edge)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [31:0] req_all;
  logic [1:0]  wr_kind;
  logic [7:0]  wr_base;
  logic [2:0]  trig_lvl;
  logic        found;
  logic [4:0]  best_slot;
  logic [4:0]  best_pr;
  logic        best_qual;
  logic [4:0]  pr;

  assign trig_lvl = st_r.control_r[VIC_CTL_TRIG_LSB +: 3];
  assign wr_kind  = i_addr[3:2];
  assign wr_base  = {i_addr[7:4], 4'h0};

  always_comb
  begin
    st_nxt    = st_r;
    found     = 1'b0;
    best_slot = 5'h0;
    best_pr   = 5'h0;
    best_qual = 1'b0;
    pr        = 5'h0;
    req_all   = i_src_req;
    req_all[VIC_EXT_SRC_LSB +: VIC_NUM_EXT] = i_src_req[VIC_EXT_SRC_LSB +: VIC_NUM_EXT]
                                            | ext_edge;

    // register writes with aliases
    if (i_wr)
    begin
      case (wr_base)
        VIC_OFF_CONTROL: st_nxt.control_r = alias_wr(st_r.control_r, i_wdata, wr_kind,
                                                     VIC_CTL_MASK);
        VIC_OFF_STATUS:  st_nxt.status_r  = alias_wr(st_r.status_r, i_wdata, wr_kind,
                                                     VIC_STAT_MASK);
        VIC_OFF_RELOAD:  st_nxt.reload_r  = alias_wr(st_r.reload_r, i_wdata, wr_kind,
                                                     '1);
        VIC_OFF_PENDING: st_nxt.pending_r = alias_wr(st_r.pending_r, i_wdata, wr_kind,
                                                     '1);
        VIC_OFF_ENABLE:  st_nxt.enable_r  = alias_wr(st_r.enable_r, i_wdata, wr_kind,
                                                     '1);
        VIC_OFF_PRIO_LO: st_nxt.prio_lo_r = alias_wr(st_r.prio_lo_r, i_wdata, wr_kind,
                                                     VIC_PRIO_MASK);
        VIC_OFF_PRIO_HI: st_nxt.prio_hi_r = alias_wr(st_r.prio_hi_r, i_wdata, wr_kind,
                                                     VIC_PRIO_MASK);
        default:         st_nxt.status_r  = st_r.status_r;
      endcase
      if (i_addr == VIC_OFF_EVT_CLR)
        st_nxt.evt_r = st_r.evt_r & ~i_wdata[VIC_NUM_EVT-1:0];
      if (i_addr == VIC_OFF_EVT_EN)
        st_nxt.evt_en_r = i_wdata[VIC_NUM_EVT-1:0];
    end

    // request sets pending, wins over clear
    st_nxt.pending_r = st_nxt.pending_r | req_all;

    // highest enabled, non-zero priority pending source (lowest index on tie)
    // one flat 32-way compare per cycle: small, but the longest path here
    for (int n = 0; n < VIC_NUM_SRC; n++)
    begin
      pr = prio_of(st_r.prio_lo_r, st_r.prio_hi_r, n);
      if (st_r.pending_r[n] && st_r.enable_r[n] && pr[4:2] != VIC_PRIO_DISABLED)
      begin
        if (!found || pr > best_pr)
        begin
          found     = 1'b1;
          best_pr   = pr;
          best_slot = 5'(n);
        end
      end
    end

    // qualifying level at or below trigger
    best_qual = (trig_lvl != VIC_TRIG_OFF) && (best_pr[4:2] <= trig_lvl);

    // proximity timer: it only defers presentation; requests keep
    // collecting in the pending flags while it runs, so none is lost
    st_nxt.cpu_r.valid = 1'b0;
    case (st_r.tmr_r)
      VIC_TMR_IDLE:
      begin
        if (found && best_qual)
        begin
          st_nxt.timer_r = st_r.reload_r;
          st_nxt.tmr_r   = VIC_TMR_RUN;
        end
        else if (found)
        begin
          st_nxt.cpu_r.valid = 1'b1;
        end
      end
      VIC_TMR_RUN:
      begin
        // hold off qualifying requests while running
        if (trig_lvl == VIC_TRIG_OFF || st_r.timer_r == 32'h0)
          st_nxt.tmr_r = VIC_TMR_DONE;
        else
          st_nxt.timer_r = st_r.timer_r - 32'h1;
        if (found && !best_qual)
          st_nxt.cpu_r.valid = 1'b1;
      end
      VIC_TMR_DONE:
      begin
        st_nxt.evt_r[VIC_EVT_TMR_EXPIRE] = 1'b1;
        st_nxt.tmr_r                     = VIC_TMR_IDLE;
        st_nxt.cpu_r.valid               = found;
      end
      default: st_nxt.tmr_r = VIC_TMR_IDLE;
    endcase

    if (st_nxt.cpu_r.valid)
    begin
      st_nxt.cpu_r.level = best_pr[4:2];
      st_nxt.cpu_r.slot  = best_slot;
      st_nxt.status_r = {21'h0, best_pr[4:2], 2'h0, 1'b0, best_slot};
      st_nxt.evt_r[VIC_EVT_PRESENT] = 1'b1;
      // presenting consumes the pending flag
      st_nxt.pending_r[best_slot] = req_all[best_slot];
    end

    // reads of unmapped offsets return zero
    st_nxt.rdata_r = 32'h0;
    if (i_rd)
    begin
      case (wr_base)
        VIC_OFF_CONTROL: st_nxt.rdata_r = st_r.control_r;
        VIC_OFF_STATUS:  st_nxt.rdata_r = st_r.status_r;
        VIC_OFF_RELOAD:  st_nxt.rdata_r = st_r.reload_r;
        VIC_OFF_PENDING: st_nxt.rdata_r = st_r.pending_r;
        VIC_OFF_ENABLE:  st_nxt.rdata_r = st_r.enable_r;
        VIC_OFF_PRIO_LO: st_nxt.rdata_r = st_r.prio_lo_r;
        VIC_OFF_PRIO_HI: st_nxt.rdata_r = st_r.prio_hi_r;
        VIC_OFF_EVT_STAT:
          st_nxt.rdata_r = (i_addr == VIC_OFF_EVT_STAT) ? 32'(st_r.evt_r) : 32'h0;
        default:         st_nxt.rdata_r = 32'h0;
      endcase
      if (wr_kind != VIC_ALIAS_PLAIN && wr_base != VIC_OFF_EVT_STAT)
        st_nxt.rdata_r = 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_r       <= '0;
      st_r.tmr_r <= VIC_TMR_IDLE;
    end
    else
      st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_rdata      = st_r.rdata_r;
  assign o_cpu_req    = st_r.cpu_r;
  assign o_multi_slot = st_r.control_r[VIC_CTL_MULTI_BIT];
  assign o_irq        = |(st_r.evt_r & st_r.evt_en_r);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  a_reserved_zero: assert property ((st_r.status_r & ~VIC_STAT_MASK) == 32'h0 &&
    (st_r.control_r & ~VIC_CTL_MASK) == 32'h0)
    else $error("unimplemented bits nonzero");
  a_report_level: assert property (st_r.cpu_r.valid |->
    st_r.status_r[10:8] == st_r.cpu_r.level && st_r.status_r[4:0] == st_r.cpu_r.slot)
    else $error("reported level or slot mismatch");
  a_report_slot: assert property (st_r.cpu_r.valid |-> st_r.status_r[5] == 1'b0)
    else $error("slot report out of range");
  a_pend_set: assert property (i_src_req[20] |=> st_r.pending_r[20] ||
    (st_r.cpu_r.valid && st_r.cpu_r.slot == 5'h14))
    else $error("request did not set pending");
  a_timer_off: assert property (trig_lvl == VIC_TRIG_OFF && st_r.tmr_r == VIC_TMR_IDLE
    |=> st_r.tmr_r != VIC_TMR_RUN)
    else $error("timer started while disabled");
  a_timer_load: assert property (st_r.tmr_r == VIC_TMR_IDLE && $past(st_r.tmr_r) != VIC_TMR_RUN
    ##1 st_r.tmr_r == VIC_TMR_RUN |-> st_r.timer_r == $past(st_r.reload_r))
    else $error("timer not loaded from reload");
  a_trig_start: assert property (st_r.tmr_r == VIC_TMR_IDLE && found && best_qual
    |=> st_r.tmr_r == VIC_TMR_RUN)
    else $error("qualifying request did not start timer");
  a_hold_off: assert property (st_r.tmr_r == VIC_TMR_RUN && found && best_qual
    |=> !st_r.cpu_r.valid)
    else $error("qualifying request presented while timer runs");
  a_enable_gate: assert property (st_r.cpu_r.valid |->
    (($past(st_r.enable_r) >> st_r.cpu_r.slot) & 32'h1) != 32'h0)
    else $error("disabled source presented");
  a_mode_out: assert property (o_multi_slot == st_r.control_r[12])
    else $error("mode output mismatch");

  // ----------------------------------------------------------------
  // assertions: edges, presentation, timer
  // ----------------------------------------------------------------
  // edges are judged on the sampled pin history; a pin held high through
  // reset may miss one falling edge just after it
  a_rise_edge: assert property ($rose(i_ext_pin[0]) && st_r.control_r[0] |->
    ext_edge[0])
    else $error("rising edge missed");
  a_fall_edge: assert property ($fell(i_ext_pin[1]) && !st_r.control_r[1] |->
    ext_edge[1])
    else $error("falling edge missed");
  a_present_pend: assert property (st_r.cpu_r.valid |->
    (($past(st_r.pending_r) >> st_r.cpu_r.slot) & 32'h1) != 32'h0)
    else $error("presented source was not pending");
  a_prio_nonzero: assert property (st_r.cpu_r.valid |->
    st_r.cpu_r.level != VIC_PRIO_DISABLED)
    else $error("zero priority source presented");
  a_quick_present: assert property (st_r.tmr_r == VIC_TMR_IDLE &&
    found && !best_qual |=> st_r.cpu_r.valid)
    else $error("non-qualifying request was delayed");
  a_done_present: assert property (st_r.tmr_r == VIC_TMR_DONE && found
    |=> st_r.cpu_r.valid)
    else $error("held request not presented at expiry");
  a_timer_count: assert property (st_r.tmr_r == VIC_TMR_RUN &&
    trig_lvl != VIC_TRIG_OFF && st_r.timer_r != 32'h0
    |=> st_r.timer_r == $past(st_r.timer_r) - 32'h1)
    else $error("proximity timer did not count down");

  // the read data register is zero outside its one valid cycle
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_alias_read: assert property ($past(i_rd) && $past(wr_kind) != VIC_ALIAS_PLAIN &&
    $past(wr_base) != VIC_OFF_EVT_STAT |-> o_rdata == 32'h0)
    else $error("alias read not zero");

  c_present:    cover property (st_r.cpu_r.valid);
  c_timer_run:  cover property (st_r.tmr_r == VIC_TMR_RUN ##1 st_r.tmr_r == VIC_TMR_DONE);
  c_ext_edge:   cover property (|ext_edge);
  c_irq:        cover property (o_irq);
  c_hold_off:   cover property (st_r.tmr_r == VIC_TMR_RUN && found && best_qual);

endmodule

//--- hw/vic_pkg.sv
/*
  package for the vectored interrupt control/status block: register offsets,
  field positions, reset values and carrier structs.
  assumes a single system clock and a plain strobe register port.
*/
package vic_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] VIC_OFF_CONTROL  = 8'h00;
  localparam logic [7:0] VIC_OFF_STATUS   = 8'h10;
  localparam logic [7:0] VIC_OFF_RELOAD   = 8'h20;
  localparam logic [7:0] VIC_OFF_PENDING  = 8'h30;
  localparam logic [7:0] VIC_OFF_ENABLE   = 8'h40;
  localparam logic [7:0] VIC_OFF_PRIO_LO  = 8'h50;
  localparam logic [7:0] VIC_OFF_PRIO_HI  = 8'h60;
  localparam logic [7:0] VIC_OFF_EVT_STAT = 8'h70;
  localparam logic [7:0] VIC_OFF_EVT_CLR  = 8'h74;
  localparam logic [7:0] VIC_OFF_EVT_EN   = 8'h78;

  // alias sub-offsets: plain, clear, set, invert
  localparam logic [1:0] VIC_ALIAS_PLAIN  = 2'h0;
  localparam logic [1:0] VIC_ALIAS_CLR    = 2'h1;
  localparam logic [1:0] VIC_ALIAS_SET    = 2'h2;
  localparam logic [1:0] VIC_ALIAS_INV    = 2'h3;

  // ----------------------------------------------------------------
  // field positions and masks
  // ----------------------------------------------------------------
  localparam int          VIC_CTL_MULTI_BIT   = 12;
  localparam int          VIC_CTL_TRIG_LSB    = 8;
  localparam int          VIC_STAT_LVL_LSB    = 8;
  localparam int          VIC_EXT_SRC_LSB     = 0;
  localparam int          VIC_NUM_EXT         = 5;
  localparam int          VIC_NUM_SRC         = 32;
  localparam logic [31:0] VIC_CTL_MASK        = 32'h0000_171f;
  localparam logic [31:0] VIC_STAT_MASK       = 32'h0000_073f;
  localparam logic [31:0] VIC_PRIO_MASK       = 32'h1f1f_1f1f;
  localparam logic [31:0] VIC_REG_RESET       = 32'h0000_0000;
  localparam logic [2:0]  VIC_TRIG_OFF        = 3'h0;
  localparam logic [2:0]  VIC_PRIO_DISABLED   = 3'h0;

  // event bits of the event status register
  localparam int          VIC_EVT_PRESENT     = 0;
  localparam int          VIC_EVT_TMR_EXPIRE  = 1;
  localparam int          VIC_NUM_EVT         = 2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } vic_bus_req_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] level;
    logic [4:0] slot;
  } vic_cpu_req_t;

  typedef enum logic [1:0] {
    VIC_TMR_IDLE,
    VIC_TMR_RUN,
    VIC_TMR_DONE
  } vic_tmr_state_t;

endpackage

//--- hw/vic_edge_detect.sv
/*
  edge detector for the external interrupt inputs, polarity per input.
  assumes the inputs are already synchronous to the system clock.
*/
module vic_edge_detect
  import vic_pkg::*;
(
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rst,
  input  wire logic [VIC_NUM_EXT-1:0] i_pin,
  input  wire logic [VIC_NUM_EXT-1:0] i_rising,
  output logic      [VIC_NUM_EXT-1:0] o_edge
);

  typedef struct packed {
    logic [VIC_NUM_EXT-1:0] prev_r;
  } vic_edge_state_t;

  vic_edge_state_t st_r;
  vic_edge_state_t st_nxt;

  always_comb
  begin
    st_nxt.prev_r = i_pin;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  genvar g;
  generate
    for (g = 0; g < VIC_NUM_EXT; g++)
    begin : g_edge
      assign o_edge[g] = i_rising[g] ? (i_pin[g] & ~st_r.prev_r[g])
                                     : (~i_pin[g] & st_r.prev_r[g]);
    end
  endgenerate

endmodule

//--- test/vic_cpu_model.sv
/*
  processor-side model: accepts vectored requests from the controller in
  single-slot mode only and keeps a count and the last slot number taken.
  assumes o_cpu_req.valid is a one-cycle pulse on the system clock.
*/
module vic_cpu_model
(
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rst,
  input  wire vic_pkg::vic_cpu_req_t i_cpu_req,
  input  wire logic                  i_multi_slot,
  output logic      [15:0]           o_taken_cnt,
  output logic      [4:0]            o_last_slot
);
  timeunit 1ns;
  timeprecision 100ps;
  import vic_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic [4:0]  slot;
  } vic_cpum_state_t;

  vic_cpum_state_t state_r;
  vic_cpum_state_t state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    // single mode only
    // the reported slot is meaningless in multi-slot mode, so ignore it there
    if (i_cpu_req.valid && !i_multi_slot)
    begin
      state_nxt.cnt  = state_r.cnt + 16'h0001;
      state_nxt.slot = i_cpu_req.slot;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  assign o_taken_cnt = state_r.cnt;
  assign o_last_slot = state_r.slot;
endmodule

//--- test/tb.sv
/*
  self-checking bench for the vectored interrupt control/status block.
  assumes the strobe register port and the cpu model beside the design.
*/
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import vic_pkg::*;

  logic                 i_clk_sys;
  logic                 i_rst;
  logic                 i_wr;
  logic                 i_rd;
  logic                 o_multi_slot;
  logic                 o_irq;
  logic                 rd_flag = 1'b0;
  logic [7:0]           i_addr;
  logic [31:0]          i_wdata;
  logic [31:0]          i_src_req;
  logic [31:0]          o_rdata;
  logic [31:0]          rv;
  logic [4:0]           i_ext_pin;
  logic [4:0]           last_slot;
  logic [15:0]          taken;
  vic_cpu_req_t         o_cpu_req;
  logic [31:0]          exp_rd[$];
  logic [7:0]           exp_cpu[$];
  int                   n_fail;
  int                   cmp_count;
  int                   seed;
  int                   lat;
  int                   cls;
  logic [2:0]           trg [6] = '{3'h3, 3'h3, 3'h0, 3'h7, 3'h1, 3'h1};
  logic [2:0]           pr  [6] = '{3'h3, 3'h4, 3'h3, 3'h7, 3'h1, 3'h2};
  logic [31:0]          dl  [6] = '{32'h1, 32'h0, 32'h0, 32'h1, 32'h1, 32'h0};

  vic_control_status u_dut (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_src_req(i_src_req),
    .i_ext_pin(i_ext_pin), .o_cpu_req(o_cpu_req), .o_multi_slot(o_multi_slot),
    .o_irq(o_irq));

  vic_cpu_model u_cpu (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cpu_req(o_cpu_req),
    .i_multi_slot(o_multi_slot), .o_taken_cnt(taken), .o_last_slot(last_slot));

  initial
  begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (n_fail == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    @(posedge i_clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(posedge i_clk_sys);
  endtask

  task automatic pulse(input logic [31:0] m);
    i_src_req <= m;
    @(posedge i_clk_sys);
    i_src_req <= '0;
  endtask

  // counts falling edges until the next presentation
  task automatic wait_cpu(output int n);
    n = 0;
    do
    begin
      @(negedge i_clk_sys);
      n++;
    end while (o_cpu_req.valid !== 1'b1 && n < 200);
    if (n >= 200)
    begin
      n_fail++;
      print_verdict();
    end
    @(posedge i_clk_sys);
  endtask

  // ----------------------------------------------------------------
  // result watcher: read data and presentations against the notes
  // ----------------------------------------------------------------
  always @(negedge i_clk_sys)
  begin
    if (rd_flag)
    begin
      if (exp_rd.size() == 0)
        cmp("rd_queue", 32'h1, 32'h0);
      else
        cmp("rdata", exp_rd.pop_front(), o_rdata);
    end
    rd_flag = i_rd;
    if (o_cpu_req.valid === 1'b1)
    begin
      if (exp_cpu.size() == 0)
        cmp("cpu_unexpected", 32'h0, 32'h1);
      else
        cmp("cpu_req", {24'h0, exp_cpu.pop_front()}, {24'h0, o_cpu_req.level, o_cpu_req.slot});
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 33;
    n_fail = 0;
    cmp_count = 0;
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = '0;
    i_wdata = '0;
    i_src_req = '0;
    i_ext_pin = '0;
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(posedge i_clk_sys);
    for (int k = 0; k < 4; k++)
      rd(8'(k * 16), VIC_REG_RESET);
    cmp("multi", 32'h0, {31'h0, o_multi_slot});
    for (int k = 0; k < 3; k++)
    begin
      rv = $random(seed);
      wr(VIC_OFF_CONTROL, rv);
      rd(VIC_OFF_CONTROL, rv & VIC_CTL_MASK);
      wr(VIC_OFF_STATUS, rv);
      rd(VIC_OFF_STATUS, rv & VIC_STAT_MASK);
      wr(VIC_OFF_RELOAD, rv);
      rd(VIC_OFF_RELOAD, rv);
      wr(VIC_OFF_PENDING, rv);
      rd(VIC_OFF_PENDING, rv);
    end
    wr(VIC_OFF_CONTROL, 32'hffff_ffff);
    rd(VIC_OFF_CONTROL, VIC_CTL_MASK);
    wr(VIC_OFF_CONTROL, 32'h0);
    cmp("multi", 32'h0, {31'h0, o_multi_slot});
    wr(VIC_OFF_CONTROL + 8'h08, 32'h0000_1000);
    cmp("multi", 32'h1, {31'h0, o_multi_slot});
    wr(VIC_OFF_CONTROL + 8'h04, 32'h0000_1000);
    cmp("multi", 32'h0, {31'h0, o_multi_slot});
    // edges: inputs 0 and 2 rising, the rest falling
    wr(VIC_OFF_CONTROL, 32'h0000_0005);
    wr(VIC_OFF_PENDING, 32'h0);
    i_ext_pin <= 5'h1f;
    repeat (4) @(posedge i_clk_sys);
    rd(VIC_OFF_PENDING, 32'h0000_0005);
    wr(VIC_OFF_PENDING, 32'h0);
    i_ext_pin <= 5'h00;
    repeat (4) @(posedge i_clk_sys);
    rd(VIC_OFF_PENDING, 32'h0000_001a);
    wr(VIC_OFF_PENDING, 32'h0);
    // two sources at once: priority 6 goes first
    wr(VIC_OFF_PRIO_LO, 32'h000c_0000);
    wr(VIC_OFF_PRIO_HI, 32'h0000_0018);
    wr(VIC_OFF_ENABLE, 32'h0002_0200);
    exp_cpu.push_back({3'h6, 5'h11});
    exp_cpu.push_back({3'h3, 5'h09});
    pulse(32'h0002_0200);
    repeat (8) @(posedge i_clk_sys);
    rd(VIC_OFF_STATUS, 32'h0000_0309);
    rd(VIC_OFF_PENDING, 32'h0);
    cmp("irq", 32'h0, {31'h0, o_irq});
    wr(VIC_OFF_EVT_EN, 32'h1);
    cmp("irq", 32'h1, {31'h0, o_irq});
    wr(VIC_OFF_EVT_CLR, 32'h1);
    cmp("irq", 32'h0, {31'h0, o_irq});
    rd(VIC_OFF_EVT_STAT, 32'h0);
    // source 5 not enabled, source 24 enabled at priority zero
    wr(VIC_OFF_ENABLE, 32'h0102_0200);
    pulse(32'h0100_0020);
    repeat (6) @(posedge i_clk_sys);
    rd(VIC_OFF_PENDING, 32'h0100_0020);
    wr(VIC_OFF_PENDING + 8'h08, 32'h5);
    wr(VIC_OFF_PENDING + 8'h04, 32'h0100_0021);
    wr(VIC_OFF_PENDING + 8'h0c, 32'h3);
    rd(VIC_OFF_PENDING, 32'h7);
    rd(VIC_OFF_PENDING + 8'h04, 32'h0);
    rd(8'h88, 32'h0);
    wr(VIC_OFF_PENDING, 32'h0);
    // proximity timer table on source 20
    wr(VIC_OFF_RELOAD, 32'd40);
    wr(VIC_OFF_ENABLE, 32'h0010_0000);
    for (int k = 0; k < 6; k++)
    begin
      wr(VIC_OFF_CONTROL, {21'h0, trg[k], 8'h0});
      wr(VIC_OFF_PRIO_HI, {19'h0, pr[k], 10'h0});
      exp_cpu.push_back({pr[k], 5'h14});
      pulse(32'h0010_0000);
      wait_cpu(lat);
      cls = (lat <= 6) ? 0 : ((lat >= 36 && lat <= 60) ? 1 : 2);
      cmp("delay_class", dl[k], 32'(cls));
      rd(VIC_OFF_STATUS, {21'h0, pr[k], 2'h0, 6'h14});
    end
    rd(VIC_OFF_EVT_STAT, 32'h3);
    cmp("irq", 32'h1, {31'h0, o_irq});
    cmp("cpu_left", 32'h0, 32'(exp_cpu.size()));
    cmp("taken", 32'd8, {16'h0, taken});
    cmp("last_slot", 32'd20, {27'h0, last_slot});
    print_verdict();
  end
endmodule
